// ==== pingpong_link_sync_config_tb_top.sv ====
// Testbench: two modem ends joined by two link interfaces, plus checker.
// Assumes ppl_pkg constants; one 100 MHz clock feeds both ends.
`timescale 1ns/10ps
`default_nettype none
module pingpong_link_sync_config_tb_top;
   import ppl_pkg::*;
   logic       clk, rst_n, tick, a_frame, a_cnt, a_dir, b_dir, a_viol, a_fact;
   logic       b_oe, b_tco, b_rxt, b_lock, b_res;
   logic [2:0] a_cfg, b_cfg, a_maint;
   logic [1:0] a_rate, a_mtx, a_sup, b_mtx, b_sup, b_rx, b_so;
   int         bad_count, total_checks, i, ok;
   ppl_link_if lnk_a ();
   ppl_link_if lnk_b ();

   // 10 ns clock
   always #5 clk = ~clk;

   // Near end goes through the same top as the far one, in a scope of its own
   if (1'b1) begin : g_near
      ppl_peer_end ppl_peer_end_inst (
         .CLK(clk), .RST_N(rst_n), .CE(1'b1), .TX_LINK(lnk_a), .RX_LINK(lnk_b),
         .CONFIG_SELECT(a_cfg), .RATE_MODE(a_rate), .FRAME_SEL(a_frame),
         .MAINT_CHANNEL_COUNT_SEL(a_cnt), .TX_CLOCK_DIR_SEL(a_dir),
         .MAINT_CLOCK_DIR_SEL(1'b0),
         .TX_LINE_CLOCK_TICK(tick), .MAIN_TX_DATA(a_mtx), .SUPPORT_IN_CH1_2(a_sup),
         .MAIN_RX_DATA(), .SUPPORT_OUT(), .TX_CLOCK_OUT(), .TX_CLOCK_OE(),
         .RX_LINE_CLOCK_TICK(), .MAINT_CHANNELS(a_maint), .FRAME_ACTIVE(a_fact),
         .LOCKED(), .LOCK_ROLE(), .CONFIG_RESERVED(), .RATE_VIOLATION(a_viol));
   end
   ppl_peer_end ppl_peer_end_inst (
      .CLK(clk), .RST_N(rst_n), .CE(1'b1), .TX_LINK(lnk_b), .RX_LINK(lnk_a),
      .CONFIG_SELECT(b_cfg), .RATE_MODE(a_rate), .FRAME_SEL(a_frame),
      .MAINT_CHANNEL_COUNT_SEL(a_cnt), .TX_CLOCK_DIR_SEL(b_dir), .MAINT_CLOCK_DIR_SEL(1'b0),
      .TX_LINE_CLOCK_TICK(tick), .MAIN_TX_DATA(b_mtx), .SUPPORT_IN_CH1_2(b_sup),
      .MAIN_RX_DATA(b_rx), .SUPPORT_OUT(b_so), .TX_CLOCK_OUT(b_tco), .TX_CLOCK_OE(b_oe),
      .RX_LINE_CLOCK_TICK(b_rxt), .MAINT_CHANNELS(), .FRAME_ACTIVE(), .LOCKED(b_lock),
      .LOCK_ROLE(), .CONFIG_RESERVED(b_res), .RATE_VIOLATION());
   ppl_link_chk ppl_link_chk_inst (
      .clk(clk), .rst_n(rst_n), .a_burst_valid(lnk_a.burst_valid),
      .a_main_data(lnk_a.main_data), .a_support_data(lnk_a.support_data),
      .a_clock_tick(lnk_a.clock_tick), .a_rate_mode(a_rate), .b_config(b_cfg),
      .b_main_rx(b_rx), .b_support_out(b_so), .b_rx_tick(b_rxt),
      .b_tx_clock_out(b_tco), .b_tx_clock_oe(b_oe));

   // ****************
   // Expectations
   // ****************
   // Far end gets a legal partner: slave faces master, peers pair alike, else drift
   function automatic logic [2:0] mate(input logic [2:0] c);
      if (c == CFG_SLV_ACTIVE) return CFG_MST_DRIFT;
      if (c == CFG_MST_DRIFT) return CFG_SLV_ACTIVE;
      if (c == CFG_FD_MEMORY || c == CFG_FD_RANDOM) return c;
      return CFG_FD_DRIFT;
   endfunction : mate
   function automatic logic [1:0] exp_sup(input logic [1:0] rate, input logic [1:0] s);
      return (rate == 2'h1) ? s : {1'b0, s[0]};
   endfunction : exp_sup
   function automatic logic [2:0] exp_maint(input logic f, input logic c);
      return (f || c) ? MAINT_ONE : MAINT_FOUR;
   endfunction : exp_maint

   // ****************
   // Tasks
   // ****************
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_flag
   // Bounded wait on a burst (sel 0) or on lock (sel 1); a hang ends the run
   task automatic wait_for(input bit sel, input int lim);
      ok = 0;
      for (i = 0; i < lim && ok == 0; i++) begin
         @(posedge clk);
         #1;
         ok = sel ? (b_lock === 1'b1) : (lnk_a.burst_valid === 1'b1);
      end
      if (ok == 0) begin
         bad_count++;
         results();
      end
   endtask : wait_for
   // Config pins are static, so they only change inside a reset
   task automatic rst_to(input logic [2:0] code, input logic [1:0] rate);
      @(posedge clk);
      rst_n <= 1'b0;
      b_cfg <= code;
      a_cfg <= mate(code);
      b_dir <= (code != CFG_SLV_ACTIVE);
      a_dir <= (mate(code) != CFG_SLV_ACTIVE);
      a_rate <= rate;
      {a_mtx, a_sup} <= 4'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
   endtask : rst_to

   // ****************
   // Main sequence
   // ****************
   initial begin
      {clk, rst_n, tick, a_cfg, b_cfg, a_rate, a_frame, a_cnt} = '0;
      {a_mtx, a_sup, b_mtx, b_sup} = 8'h00;
      {a_dir, b_dir, bad_count, total_checks} = '0;
      a_dir = 1'b1;
      b_dir = 1'b1;
      void'($urandom(32'hb8368df7));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      // Frame select against channel count select
      for (int f = 0; f < 4; f++) begin
         @(posedge clk);
         {a_frame, a_cnt} <= f[1:0];
         @(posedge clk);
         #1;
         chk_val({1'b0, a_maint}, {1'b0, exp_maint(f[1], f[0])});
         chk_flag(a_fact, f[1]);
      end
      // Every code, reserved ones included, then one transfer across the link
      for (int c = 0; c < 8; c++) begin
         rst_to(c[2:0], 2'h0);
         @(posedge clk);
         #1;
         chk_flag(b_res, (c == 2 || c == 4));
         if (c == 5) begin
            chk_flag(b_oe, 1'b1);
         end
         @(posedge clk);
         a_mtx <= 2'($urandom());
         a_sup <= 2'($urandom());
         b_mtx <= 2'($urandom());
         b_sup <= 2'($urandom());
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         wait_for(1'b0, 300);
         @(posedge clk);
         #1;
         chk_val({2'h0, b_rx}, {2'h0, a_mtx});
         chk_val({2'h0, b_so}, {2'h0, exp_sup(2'h0, a_sup)});
      end
      // Support edges: a back-to-back pair counts once, the third edge is too many
      for (int m = 0; m < 3; m++) begin
         rst_to(CFG_FD_DRIFT, m[1:0]);
         for (int t = 0; t < 100; t++) begin
            @(posedge clk);
            tick <= 1'b1;
            if (t == 10 || t == 11 || t == 50 || t == 90) begin
               a_sup <= {1'b0, ~a_sup[0]};
            end
            if (t == 89) begin
               #1;
               chk_flag(a_viol, 1'b0);
            end
         end
         repeat (3) @(posedge clk);
         tick <= 1'b0;
         #1;
         chk_flag(a_viol, 1'b1);
      end
      // Drift pair on one clock never locks; active against drift does
      rst_to(CFG_FD_DRIFT, 2'h0);
      repeat (1000) @(posedge clk);
      #1;
      chk_flag(b_lock, 1'b0);
      rst_to(CFG_FD_ACTIVE, 2'h0);
      wait_for(1'b1, 45000);
      chk_flag(b_lock, 1'b1);
      results();
   end
endmodule : pingpong_link_sync_config_tb_top
`default_nettype wire

// ==== ppl_link_chk_chk.sv ====
// Checker for the modem pair: watches link a and the peer end's outputs.
// Assumes one clock for both ends and configuration changes only in reset.
`timescale 1ns/10ps
`default_nettype none
module ppl_link_chk
   import ppl_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       a_burst_valid,
   input wire logic [1:0] a_main_data,
   input wire logic [1:0] a_support_data,
   input wire logic       a_clock_tick,
   input wire logic [1:0] a_rate_mode,
   input wire logic [2:0] b_config,
   input wire logic [1:0] b_main_rx,
   input wire logic [1:0] b_support_out,
   input wire logic       b_rx_tick,
   input wire logic       b_tx_clock_out,
   input wire logic       b_tx_clock_oe
);
   logic settled;

   default clocking cb @(posedge clk);
   endclocking
   // Outputs still show reset values one edge after release; skip that edge
   always_ff @(posedge clk) begin
      settled <= rst_n;
   end
   default disable iff (!rst_n || !settled);

   // ****************
   // Window timing
   // ****************
   // Spacing covers both the nominal and the shortened machine cycle
   sequence s_burst;
      a_burst_valid;
   endsequence
   sequence s_next;
      ##[199:200] a_burst_valid;
   endsequence
   AST_BURST_PULSE: assert property (s_burst |=> !a_burst_valid)
      else $error("burst wider than one cycle");
   AST_BURST_GAP: assert property (s_burst |=> not (##[0:197] a_burst_valid))
      else $error("burst came early");
   AST_BURST_NEXT: assert property (s_burst |-> s_next)
      else $error("next burst missing");

   // ****************
   // Data and clocks
   // ****************
   // Main and support bits must land together, then hold
   AST_RX_DATA: assert property (s_burst |=> (b_main_rx == $past(a_main_data))
      && (b_support_out == $past(a_support_data)))
      else $error("received data not in phase");
   AST_RX_HOLD: assert property (!a_burst_valid |=>
      $stable(b_main_rx) && $stable(b_support_out))
      else $error("received data moved between bursts");
   AST_CH2_IDLE: assert property (a_rate_mode != 2'h1 |-> a_support_data[1] == 1'b0)
      else $error("second support channel used outside two-channel mode");
   AST_RX_TICK: assert property ((b_config != CFG_MST_DRIFT) |=>
      b_rx_tick == $past(a_clock_tick))
      else $error("receive tick does not follow far tick");
   AST_MASTER_TICK: assert property ((b_config == CFG_MST_DRIFT) |=>
      b_rx_tick == $past(b_tx_clock_out))
      else $error("master receive tick does not follow own tick");
   AST_SLAVE_CLK: assert property ((b_config == CFG_SLV_ACTIVE) |-> b_tx_clock_oe
      && (b_tx_clock_out == a_clock_tick))
      else $error("slave transmit clock not taken from far end");
endmodule : ppl_link_chk
`default_nettype wire

// ==== ppl_link_if.sv ====
// Interface joining two ping-pong modem ends over the fibre.
// Assumes both ends run on the same clock; burst is one cycle wide.
`timescale 1ns/10ps
`default_nettype none
interface ppl_link_if;
   logic       burst_valid;   // Transmit burst present at the window slot
   logic [1:0] main_data;     // Main channel data, positive and negative rails
   logic [1:0] support_data;  // Support channel bits carried in phase
   logic       clock_tick;    // Transmit line clock tick carried for the DPLL
   logic       lock_role;     // Sender role for memory-lock arbitration

   modport near (output burst_valid, output main_data, output support_data,
                 output clock_tick, output lock_role);
   modport far  (input burst_valid, input main_data, input support_data,
                 input clock_tick, input lock_role);
endinterface : ppl_link_if
`default_nettype wire

// ==== ppl_modem_end.sv ====
// One end of a ping-pong modem pair: configuration decode, clock roles,
// support-channel transition shaping and in-phase framing. Same module
// serves both ends; the testbench joins two through ppl_link_if.
//
// Overview of operation
// - Single channel: two edges per 512 clocks
// - Dual channel: two edges per 128 own clocks
// - Half rate: two edges per 128 clocks
// - Back-to-back edges count as one
// - Main and support data travel in phase
// - Channel count select: one or four channels
// - Four channels only in maintenance mode
// - Decode six configuration codes
// - Full duplex: receive clock tracks far transmit
// - Slave: both clocks from far transmit
// - Slave needs direction selects tied low
// - Master: receive clock from own transmit
// - Machine cycle self-aligns to peer window
// - Drift lock fails at zero offset
// - Active lock shortens cycle by half percent
// - Active lock works at zero offset
// - Pair one drift and one active end
// - Random lock for identical peers: shared LFSR_SEED keeps their offset fixed
// - Memory lock arbitrates roles after reset
// - Memory role rerun at each window while unlocked
// - Frame select picks frame or maintenance
// - Never pair two active ends unlocked
`timescale 1ns/10ps
`default_nettype none
module ppl_modem_end
   import ppl_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       CE,
   ppl_link_if.near        TX_LINK,
   ppl_link_if.far         RX_LINK,
   input  wire logic [2:0] CONFIG_SELECT,
   input  wire logic [1:0] RATE_MODE,
   input  wire logic       FRAME_SEL,
   input  wire logic       MAINT_CHANNEL_COUNT_SEL,
   input  wire logic       TX_CLOCK_DIR_SEL,
   input  wire logic       MAINT_CLOCK_DIR_SEL,
   input  wire logic       TX_LINE_CLOCK_TICK,
   input  wire logic [1:0] MAIN_TX_DATA,
   input  wire logic [1:0] SUPPORT_IN_CH1_2,
   output logic [1:0]      MAIN_RX_DATA,
   output logic [1:0]      SUPPORT_OUT,
   output logic            TX_CLOCK_OUT,
   output logic            TX_CLOCK_OE,
   output logic            RX_LINE_CLOCK_TICK,
   output logic [2:0]      MAINT_CHANNELS,
   output logic            FRAME_ACTIVE,
   output logic            LOCKED,
   output logic            LOCK_ROLE,
   output logic            CONFIG_RESERVED,
   output logic            RATE_VIOLATION
);
   ppl_lock_t  lock_mode;
   ppl_clk_t   clk_mode;
   logic       win_tx;
   logic       tx_tick_src;
   logic [9:0] win_len;
   logic [1:0] sup_prev;
   logic [1:0] sup_edge;
   logic [1:0] edge_last;
   logic [9:0] win_cnt [2];
   logic [1:0] edge_cnt [2];
   logic [1:0] viol;
   logic [1:0] sup_hold;
   logic [1:0] main_hold;

   // ****************************************************************
   // Configuration decode
   // ****************************************************************
   // Reserved codes fall back to plain full duplex with drift lock
   assign lock_mode       = ppl_lock_of(CONFIG_SELECT);
   assign clk_mode        = ppl_clk_of(CONFIG_SELECT);
   assign CONFIG_RESERVED = (lock_mode == PPL_RESERVED);
   assign FRAME_ACTIVE    = FRAME_SEL;
   // Four maintenance channels exist only outside frame mode
   assign MAINT_CHANNELS  = (MAINT_CHANNEL_COUNT_SEL || FRAME_SEL) ? MAINT_ONE
                                                                   : MAINT_FOUR;

   // ****************************************************************
   // Clock relationships
   // ****************************************************************
   // Slave ignores the direction select: the system must tie it low
   assign TX_CLOCK_OE  = (clk_mode == PPL_SLAVE) || !TX_CLOCK_DIR_SEL;
   // Slave transmits on the far clock; others on their own clock
   assign tx_tick_src  = (clk_mode == PPL_SLAVE) ? RX_LINK.clock_tick
                                                 : TX_LINE_CLOCK_TICK;
   assign TX_CLOCK_OUT = tx_tick_src;

   // Receive tick: master loops its own transmit tick, others follow the
   // far-end tick one cycle late, so the average rates match exactly.
   // No pending store: it would turn two back-to-back ticks into three
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RX_LINE_CLOCK_TICK <= 1'b0;
      end else if (CE) begin
         if (clk_mode == PPL_MASTER) begin
            RX_LINE_CLOCK_TICK <= TX_LINE_CLOCK_TICK;
         end else begin
            RX_LINE_CLOCK_TICK <= RX_LINK.clock_tick;
         end
      end
   end

   // ****************************************************************
   // Support-channel transition limits
   // ****************************************************************
   always_comb begin
      unique case (RATE_MODE)
         PPL_SINGLE: win_len = WIN_SINGLE;
         PPL_DUAL:   win_len = WIN_DUAL;
         default:    win_len = WIN_HALF;
      endcase
   end

   assign sup_edge = (SUPPORT_IN_CH1_2 ^ sup_prev) & {2{TX_LINE_CLOCK_TICK}};

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sup_prev  <= 2'h0;
         edge_last <= 2'h0;
      end else if (CE && TX_LINE_CLOCK_TICK) begin
         sup_prev  <= SUPPORT_IN_CH1_2;
         edge_last <= sup_edge;
      end
   end

   // One window counter per channel; channel 2 is live only in dual mode
   for (genvar ch = 0; ch < 2; ch++) begin : g_limit
      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            win_cnt[ch]  <= 10'h0_000;
            edge_cnt[ch] <= 2'h0;
            viol[ch]     <= 1'b0;
         end else if (CE && TX_LINE_CLOCK_TICK) begin
            if (win_cnt[ch] + MACH_ONE >= win_len) begin
               win_cnt[ch]  <= 10'h0_000;
               edge_cnt[ch] <= 2'h0;
            end else begin
               win_cnt[ch] <= win_cnt[ch] + MACH_ONE;
               // An edge right after an edge is folded into the first
               if (sup_edge[ch] && !edge_last[ch]) begin
                  if (edge_cnt[ch] == MAX_TRANS) begin
                     viol[ch] <= (ch == 0) || (RATE_MODE == PPL_DUAL);
                  end else begin
                     edge_cnt[ch] <= edge_cnt[ch] + 2'h1;
                  end
               end
            end
         end
      end
   end
   assign RATE_VIOLATION = |viol;

   // ****************************************************************
   // In-phase link framing
   // ****************************************************************
   // Main and support data are sampled together and sent in one burst
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         main_hold <= 2'h0;
         sup_hold  <= 2'h0;
      end else if (CE && tx_tick_src) begin
         main_hold <= MAIN_TX_DATA;
         sup_hold  <= (RATE_MODE == PPL_DUAL) ? SUPPORT_IN_CH1_2
                                             : {1'b0, SUPPORT_IN_CH1_2[0]};
      end
   end

   assign TX_LINK.burst_valid  = win_tx;
   assign TX_LINK.main_data    = main_hold;
   assign TX_LINK.support_data = sup_hold;
   assign TX_LINK.clock_tick   = tx_tick_src;
   assign TX_LINK.lock_role    = LOCK_ROLE;

   // Far-end side presents both together from one burst
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         MAIN_RX_DATA <= 2'h0;
         SUPPORT_OUT  <= 2'h0;
      end else if (CE && RX_LINK.burst_valid) begin
         MAIN_RX_DATA <= RX_LINK.main_data;
         SUPPORT_OUT  <= RX_LINK.support_data;
      end
   end

   // ****************************************************************
   // Window lock
   // ****************************************************************
   ppl_window_lock u_lock (
      .clk       (CLK),
      .rst_n     (RST_N),
      .ce        (CE),
      .lock_mode (lock_mode),
      .peer_seen (RX_LINK.burst_valid),
      .peer_role (RX_LINK.lock_role),
      .win_tx    (win_tx),
      .locked    (LOCKED),
      .role      (LOCK_ROLE)
   );
endmodule : ppl_modem_end
`default_nettype wire

// ==== ppl_peer_end.sv ====
// Either end of the pair: an identical peer modem. Wraps the same end
// logic, passing the link ports straight through. Assumes testbench joins two ifs.
`timescale 1ns/10ps
`default_nettype none
module ppl_peer_end
   import ppl_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       CE,
   ppl_link_if.near        TX_LINK,
   ppl_link_if.far         RX_LINK,
   input  wire logic [2:0] CONFIG_SELECT,
   input  wire logic [1:0] RATE_MODE,
   input  wire logic       FRAME_SEL,
   input  wire logic       MAINT_CHANNEL_COUNT_SEL,
   input  wire logic       TX_CLOCK_DIR_SEL,
   input  wire logic       MAINT_CLOCK_DIR_SEL,
   input  wire logic       TX_LINE_CLOCK_TICK,
   input  wire logic [1:0] MAIN_TX_DATA,
   input  wire logic [1:0] SUPPORT_IN_CH1_2,
   output logic [1:0]      MAIN_RX_DATA,
   output logic [1:0]      SUPPORT_OUT,
   output logic            TX_CLOCK_OUT,
   output logic            TX_CLOCK_OE,
   output logic            RX_LINE_CLOCK_TICK,
   output logic [2:0]      MAINT_CHANNELS,
   output logic            FRAME_ACTIVE,
   output logic            LOCKED,
   output logic            LOCK_ROLE,
   output logic            CONFIG_RESERVED,
   output logic            RATE_VIOLATION
);
   // Pairing rules are not enforced here; the testbench mate function
   // gives each end a legal partner code
   ppl_modem_end u_end (
      .CLK                     (CLK),
      .RST_N                   (RST_N),
      .CE                      (CE),
      .TX_LINK                 (TX_LINK),
      .RX_LINK                 (RX_LINK),
      .CONFIG_SELECT           (CONFIG_SELECT),
      .RATE_MODE               (RATE_MODE),
      .FRAME_SEL               (FRAME_SEL),
      .MAINT_CHANNEL_COUNT_SEL (MAINT_CHANNEL_COUNT_SEL),
      .TX_CLOCK_DIR_SEL        (TX_CLOCK_DIR_SEL),
      .MAINT_CLOCK_DIR_SEL     (MAINT_CLOCK_DIR_SEL),
      .TX_LINE_CLOCK_TICK      (TX_LINE_CLOCK_TICK),
      .MAIN_TX_DATA            (MAIN_TX_DATA),
      .SUPPORT_IN_CH1_2        (SUPPORT_IN_CH1_2),
      .MAIN_RX_DATA            (MAIN_RX_DATA),
      .SUPPORT_OUT             (SUPPORT_OUT),
      .TX_CLOCK_OUT            (TX_CLOCK_OUT),
      .TX_CLOCK_OE             (TX_CLOCK_OE),
      .RX_LINE_CLOCK_TICK      (RX_LINE_CLOCK_TICK),
      .MAINT_CHANNELS          (MAINT_CHANNELS),
      .FRAME_ACTIVE            (FRAME_ACTIVE),
      .LOCKED                  (LOCKED),
      .LOCK_ROLE               (LOCK_ROLE),
      .CONFIG_RESERVED         (CONFIG_RESERVED),
      .RATE_VIOLATION          (RATE_VIOLATION)
   );
endmodule : ppl_peer_end
`default_nettype wire

// ==== ppl_pkg.sv ====
// Package for the ping-pong link configuration and window-lock logic.
// Assumes a single 100 MHz system clock shared by both ends.
package ppl_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int          CLK_MHZ         = 100;
   localparam int          CYCLE_NS        = 10;
   // Nominal machine cycle of the ping-pong window, in clocks
   localparam logic [9:0]  MACH_NOM        = 10'h0_0C8;
   // Active lock shortens the cycle by 0.5 percent (one clock in 200)
   localparam logic [9:0]  MACH_SHORT      = 10'h0_0C7;
   localparam logic [9:0]  MACH_ZERO       = 10'h0_000;
   localparam logic [9:0]  MACH_ONE        = 10'h0_001;
   // Lock time budgets in milliseconds
   localparam int          ACTIVE_LOCK_MS  = 1000;
   localparam int          RANDOM_LOCK_MS  = 3000;
   localparam int          ARB_LOCK_MS     = 2000;
   // Cycles of the 100 MHz clock for the lock budgets
   localparam int          ACTIVE_LOCK_CYC = ACTIVE_LOCK_MS * 1000 * CLK_MHZ;
   localparam int          RANDOM_LOCK_CYC = RANDOM_LOCK_MS * 1000 * CLK_MHZ;
   localparam int          ARB_LOCK_CYC    = ARB_LOCK_MS * 1000 * CLK_MHZ;

   // ****************************************************************
   // Support-channel transition limits
   // ****************************************************************
   localparam logic [9:0]  WIN_SINGLE      = 10'h0_200;
   localparam logic [9:0]  WIN_DUAL        = 10'h0_080;
   localparam logic [9:0]  WIN_HALF        = 10'h0_080;
   localparam logic [1:0]  MAX_TRANS       = 2'h2;

   // ****************************************************************
   // Configuration codes
   // ****************************************************************
   localparam logic [2:0]  CFG_FD_DRIFT    = 3'h0;
   localparam logic [2:0]  CFG_FD_MEMORY   = 3'h1;
   localparam logic [2:0]  CFG_FD_RANDOM   = 3'h3;
   localparam logic [2:0]  CFG_SLV_ACTIVE  = 3'h5;
   localparam logic [2:0]  CFG_MST_DRIFT   = 3'h6;
   localparam logic [2:0]  CFG_FD_ACTIVE   = 3'h7;

   typedef enum logic [1:0] {PPL_FULL_DUPLEX, PPL_SLAVE, PPL_MASTER} ppl_clk_t;
   typedef enum logic [2:0] {PPL_DRIFT, PPL_ACTIVE, PPL_RANDOM, PPL_MEMORY,
                             PPL_RESERVED} ppl_lock_t;
   typedef enum logic [1:0] {PPL_SINGLE, PPL_DUAL, PPL_HALF} ppl_rate_t;

   // Memory-lock role stored on chip
   localparam logic        ROLE_DRIFT      = 1'b0;
   localparam logic        ROLE_ACTIVE     = 1'b1;
   // Maintenance channel counts
   localparam logic [2:0]  MAINT_ONE       = 3'h1;
   localparam logic [2:0]  MAINT_FOUR      = 3'h4;
   // LFSR seed for random lock (arbitrary, non-zero)
   localparam logic [15:0] LFSR_SEED       = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS       = 16'hB400;

   // Decode of the configuration code, shared by both ends
   function automatic ppl_lock_t ppl_lock_of(input logic [2:0] code);
      unique case (code)
         CFG_FD_DRIFT, CFG_MST_DRIFT:   ppl_lock_of = PPL_DRIFT;
         CFG_FD_MEMORY:                 ppl_lock_of = PPL_MEMORY;
         CFG_FD_RANDOM:                 ppl_lock_of = PPL_RANDOM;
         CFG_SLV_ACTIVE, CFG_FD_ACTIVE: ppl_lock_of = PPL_ACTIVE;
         default:                       ppl_lock_of = PPL_RESERVED;
      endcase
   endfunction : ppl_lock_of

   function automatic ppl_clk_t ppl_clk_of(input logic [2:0] code);
      unique case (code)
         CFG_SLV_ACTIVE: ppl_clk_of = PPL_SLAVE;
         CFG_MST_DRIFT:  ppl_clk_of = PPL_MASTER;
         default:        ppl_clk_of = PPL_FULL_DUPLEX;
      endcase
   endfunction : ppl_clk_of

endpackage : ppl_pkg

// ==== ppl_window_lock.sv ====
// Window lock engine: machine-cycle counter with drift, active, random
// and memory lock. Assumes peer_seen pulses when a peer burst lands.
`timescale 1ns/10ps
`default_nettype none
module ppl_window_lock
   import ppl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire ppl_lock_t  lock_mode,
   input  wire logic       peer_seen,
   input  wire logic       peer_role,
   output logic            win_tx,
   output logic            locked,
   output logic            role
);
   logic [9:0]  phase;
   logic [9:0]  cycle_len;
   logic [15:0] lfsr;
   logic        shorten;

   // ****************************************************************
   // Cycle length selection
   // ****************************************************************
   // Memory lock repicks its role at each window until locked, acting as active or drift
   always_comb begin
      unique case (lock_mode)
         PPL_ACTIVE: shorten = !locked;
         PPL_RANDOM: shorten = !locked && lfsr[0];
         PPL_MEMORY: shorten = !locked && (role == ROLE_ACTIVE);
         default:    shorten = 1'b0;
      endcase
      cycle_len = shorten ? MACH_SHORT : MACH_NOM;
   end

   // Machine cycle phase; window opens at phase zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase <= MACH_ZERO;
      end else if (ce) begin
         phase <= (phase + MACH_ONE >= cycle_len) ? MACH_ZERO : phase + MACH_ONE;
      end
   end
   assign win_tx = (phase == MACH_ZERO);

   // Lock when the peer burst lands mid-cycle, the receive slot
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         locked <= 1'b0;
      end else if (ce && peer_seen) begin
         locked <= (phase == (MACH_NOM >> 1));
      end
   end

   // Random sequence; both ends load LFSR_SEED, so identical peers run it in step
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lfsr <= LFSR_SEED;
      end else if (ce && win_tx) begin
         lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
      end
   end

   // Memory role: rerun at each window while unlocked, held between windows and once locked
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         role <= ROLE_DRIFT;
      end else if (ce && lock_mode == PPL_MEMORY && !locked && win_tx) begin
         // Arbitration: take a random role (lfsr bit 1) unless the peer already claims active
         role <= (peer_role == ROLE_ACTIVE) ? ROLE_DRIFT : lfsr[1];
      end
   end
endmodule : ppl_window_lock
`default_nettype wire
